// ==== hdl/tlv_pkg.sv ====
/*
 Package for the two-level vectored interrupt unit: register offsets,
 field positions, reset values, vectors, timing counts and carrier types.
 Assumes a single 20 MHz core clock and a 12-clock machine cycle.
*/
package tlv_pkg;

	localparam int unsigned CLK_HZ            = 20_000_000;
	localparam int unsigned MACHINE_CYCLE_CLK = 12;

	// Number of sources and their index in polling order
	localparam int unsigned NUM_SRC = 6;
	localparam int unsigned SRC_EXT0 = 0;
	localparam int unsigned SRC_TMR0 = 1;
	localparam int unsigned SRC_EXT1 = 2;
	localparam int unsigned SRC_TMR1 = 3;
	localparam int unsigned SRC_UART = 4;
	localparam int unsigned SRC_TMR2 = 5;

	// Word offsets on the register bus (byte address = 4 * index)
	localparam logic [3:0] OFS_ENABLE   = 4'h0;
	localparam logic [3:0] OFS_PRIORITY = 4'h1;
	localparam logic [3:0] OFS_TIMER_CONTROL_REG     = 4'h2;
	localparam logic [3:0] OFS_FLAGS    = 4'h3;
	localparam logic [3:0] OFS_STATUS   = 4'h4;

	// Enable register fields
	localparam int unsigned EN_GLOBAL_BIT = 7;
	localparam int unsigned EN_RSVD_BIT   = 6;
	// Timer control fields
	localparam int unsigned TC_TF1_BIT = 7;
	localparam int unsigned TC_TF0_BIT = 5;
	localparam int unsigned TC_IE1_BIT = 3;
	localparam int unsigned TC_IT1_BIT = 2;
	localparam int unsigned TC_IE0_BIT = 1;
	localparam int unsigned TC_IT0_BIT = 0;
	// Flag register fields
	localparam int unsigned FL_RI_BIT   = 0;
	localparam int unsigned FL_TI_BIT   = 1;
	localparam int unsigned FL_TF2_BIT  = 2;
	localparam int unsigned FL_TIMER2_EXTERNAL_FLAG_BIT = 3;

	localparam logic [7:0] ENABLE_RESET   = 8'h00;
	localparam logic [7:0] PRIORITY_RESET = 8'h00;
	localparam logic [7:0] TIMER_CONTROL_REG_RESET     = 8'h00;
	localparam logic [7:0] ENABLE_MASK    = 8'hbf;
	localparam logic [7:0] PRIORITY_MASK  = 8'h3f;
	localparam logic [7:0] TIMER_CONTROL_REG_MASK      = 8'haf;
	localparam logic [7:0] FLAGS_MASK     = 8'h0f;

	localparam logic [15:0] VECTOR_BASE = 16'h0003;
	localparam logic [15:0] VECTOR_STEP = 16'h0008;

	typedef struct packed {
		logic       tmr2_ovf;
		logic       tmr2_ext;
		logic       uart_rx;
		logic       uart_tx;
		logic       tmr1_ovf;
		logic       tmr0_ovf;
	} tlv_hw_set_t;

	typedef struct packed {
		logic       final_cycle;
		logic       return_from_handler;
		logic       ie_ip_access;
		logic       call_done;
	} tlv_core_t;

	typedef struct packed {
		logic        req;
		logic [2:0]  src;
		logic [15:0] vector;
	} tlv_call_t;

endpackage

// ==== hdl/tlv_cycle_div.sv ====
/*
 Machine-cycle divider: one-cycle pulse at the sampling phase and at the
 polling phase of every machine cycle. Assumes one clock, async reset.
*/
module tlv_cycle_div
	import tlv_pkg::*;
#(
	parameter int unsigned DIV = MACHINE_CYCLE_CLK
) (
	input  wire logic clk,
	input  wire logic resetn,
	output logic      sample_en,
	output logic      poll_en
);

	logic [3:0] count;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= 4'h0;
		end else if (count == 4'(DIV - 1)) begin
			count <= 4'h0;
		end else begin
			count <= count + 4'h1;
		end
	end

	// Sample late in the cycle, poll on the cycle's last clock
	assign sample_en = (count == 4'(DIV - 3));
	assign poll_en   = (count == 4'(DIV - 1));

endmodule

// ==== hdl/tlv_prio_pick.sv ====
/*
 Fixed-order picker: lowest index of the request vector wins.
 Purely combinational; assumes nothing of its surroundings.
*/
module tlv_prio_pick #(
	parameter int unsigned N = 6
) (
	input  wire logic [N-1:0] req,
	output logic              any,
	output logic [2:0]        idx
);

	always_comb begin
		any = 1'b0;
		idx = 3'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = 3'(i);
			end
		end
	end

endmodule

// ==== hdl/tlv_irq_unit.sv ====
/*
 Two-level vectored interrupt unit: request flags, enables, priority,
 polling and vectored call request toward the core. Registers on an
 Avalon-MM slave. Assumes the core reports final cycle, return and call
 completion, and that peripherals pulse their set events for one clock.
*/
// Overview of operation
// - Six sources; parameter HAS_TIMER2=0 gives the five-source variant.
// - Each external pin is level or falling-edge triggered by its select bit.
// - Vectoring clears an external flag only when edge triggered.
// - Timer-0 and timer-1 rollovers set their overflow flags.
// - Vectoring clears the timer-0 or timer-1 flag that caused it.
// - Serial request is receive OR transmit flag; never cleared by vectoring.
// - Timer-2 request is overflow OR external flag; never cleared by vectoring.
// - Software set or clear of any flag acts exactly as hardware.
// - Global enable bit 7 gates all sources; each also has its own enable.
// - Enable bits 5..0: timer2, serial, timer1, ext1, timer0, ext0; bit 6 reserved.
// - Priority bits 5..0 same order, 1 is high; bits 7, 6 reserved.
// - Low routine preemptible only by high; high routine never preempted.
// - Simultaneous requests of different level: the high one wins.
// - Equal level: order ext0, timer0, ext1, timer1, serial.
// - Flags sampled once per machine cycle, polled two clocks later in the same cycle.
// - No call during equal/higher level, non-final cycle, return, or enable access earlier in the same machine cycle than the poll clock.
// - Call loads vector 0003h plus eight per source; status not saved.
// - Return from handler clears the current in-progress level only.
module tlv_irq_unit
	import tlv_pkg::*;
#(
	parameter bit HAS_TIMER2 = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic [1:0]       avs_response,
	// Pins and peripheral events
	input  wire logic        ext0_request_pin,
	input  wire logic        ext1_request_pin,
	input  wire tlv_hw_set_t hw_set,
	// Core sequencer
	input  wire tlv_core_t   core,
	output tlv_call_t        call,
	output logic [7:0]       flag_view
);

	logic [7:0] irq_enable_mask;
	logic [7:0] irq_priority_select;
	logic       ext0_edge_select, ext1_edge_select;
	logic       ext0_request_flag, ext1_request_flag;
	logic       timer0_overflow_flag, timer1_overflow_flag;
	logic       uart_rx_done_flag, uart_tx_done_flag;
	logic       timer2_overflow_flag, timer2_external_flag;
	logic       ext0_pin_q, ext1_pin_q;
	logic [1:0] in_progress;             // bit1 high level, bit0 low level
	logic [NUM_SRC-1:0] raw_req, sampled;
	logic       sample_en, poll_en;
	logic       blocked_by_access;

	// Bus strobes
	logic wr_en, wr_pri, wr_timer_control_reg, wr_flags;
	logic [7:0] wdata;
	assign wdata    = avs_writedata[7:0];
	assign wr_en    = avs_write && avs_byteenable[0] && avs_address == OFS_ENABLE;
	assign wr_pri   = avs_write && avs_byteenable[0] && avs_address == OFS_PRIORITY;
	assign wr_timer_control_reg  = avs_write && avs_byteenable[0] && avs_address == OFS_TIMER_CONTROL_REG;
	assign wr_flags = avs_write && avs_byteenable[0] && avs_address == OFS_FLAGS;

	tlv_cycle_div u_div (
		.clk       (clk),
		.resetn    (resetn),
		.sample_en (sample_en),
		.poll_en   (poll_en)
	);

	// Vectoring acknowledgement from the core
	logic       ack;
	logic [2:0] ack_src;
	assign ack     = call.req && core.call_done;
	assign ack_src = call.src;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_enable_mask     <= ENABLE_RESET;
			irq_priority_select <= PRIORITY_RESET;
		end else begin
			if (wr_en)
				irq_enable_mask <= wdata & ENABLE_MASK;
			if (wr_pri)
				irq_priority_select <= wdata & PRIORITY_MASK;
		end
	end

	// Pin history for falling-transition detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ext0_pin_q <= 1'b1;
			ext1_pin_q <= 1'b1;
		end else if (sample_en) begin
			ext0_pin_q <= ext0_request_pin;
			ext1_pin_q <= ext1_request_pin;
		end
	end

	// External flags: edge sets sticky, level follows the pin
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ext0_edge_select  <= TIMER_CONTROL_REG_RESET[TC_IT0_BIT];
			ext1_edge_select  <= TIMER_CONTROL_REG_RESET[TC_IT1_BIT];
			ext0_request_flag <= TIMER_CONTROL_REG_RESET[TC_IE0_BIT];
			ext1_request_flag <= TIMER_CONTROL_REG_RESET[TC_IE1_BIT];
		end else begin
			if (wr_timer_control_reg) begin
				ext0_edge_select <= wdata[TC_IT0_BIT];
				ext1_edge_select <= wdata[TC_IT1_BIT];
			end
			if (sample_en && ext0_edge_select && ext0_pin_q && !ext0_request_pin)
				ext0_request_flag <= 1'b1;
			else if (sample_en && !ext0_edge_select)
				ext0_request_flag <= !ext0_request_pin;
			else if (wr_timer_control_reg)
				ext0_request_flag <= wdata[TC_IE0_BIT];
			else if (ack && ack_src == 3'(SRC_EXT0) && ext0_edge_select)
				ext0_request_flag <= 1'b0;
			if (sample_en && ext1_edge_select && ext1_pin_q && !ext1_request_pin)
				ext1_request_flag <= 1'b1;
			else if (sample_en && !ext1_edge_select)
				ext1_request_flag <= !ext1_request_pin;
			else if (wr_timer_control_reg)
				ext1_request_flag <= wdata[TC_IE1_BIT];
			else if (ack && ack_src == 3'(SRC_EXT1) && ext1_edge_select)
				ext1_request_flag <= 1'b0;
		end
	end

	// Timer flags: hardware set wins over any clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer0_overflow_flag <= TIMER_CONTROL_REG_RESET[TC_TF0_BIT];
			timer1_overflow_flag <= TIMER_CONTROL_REG_RESET[TC_TF1_BIT];
		end else begin
			if (hw_set.tmr0_ovf)
				timer0_overflow_flag <= 1'b1;
			else if (wr_timer_control_reg)
				timer0_overflow_flag <= wdata[TC_TF0_BIT];
			else if (ack && ack_src == 3'(SRC_TMR0))
				timer0_overflow_flag <= 1'b0;
			if (hw_set.tmr1_ovf)
				timer1_overflow_flag <= 1'b1;
			else if (wr_timer_control_reg)
				timer1_overflow_flag <= wdata[TC_TF1_BIT];
			else if (ack && ack_src == 3'(SRC_TMR1))
				timer1_overflow_flag <= 1'b0;
		end
	end

	// Serial and timer-2 flags: software clears only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			uart_rx_done_flag    <= 1'b0;
			uart_tx_done_flag    <= 1'b0;
			timer2_overflow_flag <= 1'b0;
			timer2_external_flag <= 1'b0;
		end else begin
			if (hw_set.uart_rx)
				uart_rx_done_flag <= 1'b1;
			else if (wr_flags)
				uart_rx_done_flag <= wdata[FL_RI_BIT];
			if (hw_set.uart_tx)
				uart_tx_done_flag <= 1'b1;
			else if (wr_flags)
				uart_tx_done_flag <= wdata[FL_TI_BIT];
			if (HAS_TIMER2 && hw_set.tmr2_ovf)
				timer2_overflow_flag <= 1'b1;
			else if (HAS_TIMER2 && wr_flags)
				timer2_overflow_flag <= wdata[FL_TF2_BIT];
			if (HAS_TIMER2 && hw_set.tmr2_ext)
				timer2_external_flag <= 1'b1;
			else if (HAS_TIMER2 && wr_flags)
				timer2_external_flag <= wdata[FL_TIMER2_EXTERNAL_FLAG_BIT];
		end
	end

	always_comb begin
		raw_req[SRC_EXT0] = ext0_request_flag;
		raw_req[SRC_TMR0] = timer0_overflow_flag;
		raw_req[SRC_EXT1] = ext1_request_flag;
		raw_req[SRC_TMR1] = timer1_overflow_flag;
		raw_req[SRC_UART] = uart_rx_done_flag | uart_tx_done_flag;
		raw_req[SRC_TMR2] = HAS_TIMER2 &&
			(timer2_overflow_flag | timer2_external_flag);
	end

	// Sample once per machine cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sampled <= '0;
		else if (sample_en)
			sampled <= raw_req;
	end

	// Remember a return or enable/priority access until the next poll
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			blocked_by_access <= 1'b0;
		else if (poll_en)
			blocked_by_access <= 1'b0;
		else if (core.return_from_handler || core.ie_ip_access || wr_en || wr_pri)
			blocked_by_access <= 1'b1;
	end

	// Enabled requests split by level
	logic [NUM_SRC-1:0] enabled, hi_req, lo_req;
	logic               hi_any, lo_any;
	logic [2:0]         hi_idx, lo_idx;
	assign enabled = sampled & irq_enable_mask[NUM_SRC-1:0]
		& {NUM_SRC{irq_enable_mask[EN_GLOBAL_BIT]}};
	assign hi_req  = enabled & irq_priority_select[NUM_SRC-1:0];
	assign lo_req  = enabled & ~irq_priority_select[NUM_SRC-1:0];

	tlv_prio_pick #(.N(NUM_SRC)) u_pick_hi (
		.req (hi_req),
		.any (hi_any),
		.idx (hi_idx)
	);

	tlv_prio_pick #(.N(NUM_SRC)) u_pick_lo (
		.req (lo_req),
		.any (lo_any),
		.idx (lo_idx)
	);

	logic       can_call, win_hi;
	logic [2:0] win_idx;
	assign win_hi   = hi_any;
	assign win_idx  = hi_any ? hi_idx : lo_idx;
	assign can_call = poll_en && !call.req && core.final_cycle && !blocked_by_access
		&& !core.return_from_handler && !in_progress[1]
		&& (hi_any || (lo_any && !in_progress[0]));

	// Call request held until the core takes it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			call <= '0;
		end else if (can_call) begin
			call.req    <= 1'b1;
			call.src    <= win_idx;
			call.vector <= VECTOR_BASE + 16'(win_idx) * VECTOR_STEP;
		end else if (ack) begin
			call.req <= 1'b0;
		end
	end

	// Level in progress; level captured at call time
	logic call_hi;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			call_hi <= 1'b0;
		else if (can_call)
			call_hi <= win_hi;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			in_progress <= 2'b00;
		end else if (ack) begin
			if (call_hi)
				in_progress[1] <= 1'b1;
			else
				in_progress[0] <= 1'b1;
		end else if (core.return_from_handler) begin
			if (in_progress[1])
				in_progress[1] <= 1'b0;
			else
				in_progress[0] <= 1'b0;
		end
	end

	assign flag_view = {timer1_overflow_flag, 1'b0, timer0_overflow_flag, 1'b0,
		ext1_request_flag, ext1_edge_select, ext0_request_flag, ext0_edge_select};

	// Register reads: registered answer, one wait state
	logic [7:0] rd_byte;
	logic       mapped;
	always_comb begin
		rd_byte = 8'h00;
		mapped  = 1'b1;
		unique case (avs_address)
			OFS_ENABLE:   rd_byte = irq_enable_mask;
			OFS_PRIORITY: rd_byte = irq_priority_select;
			OFS_TIMER_CONTROL_REG:     rd_byte = flag_view;
			OFS_FLAGS:    rd_byte = {4'h0, timer2_external_flag, timer2_overflow_flag,
				uart_tx_done_flag, uart_rx_done_flag};
			OFS_STATUS:   rd_byte = {call.req, call.src, 2'b00, in_progress};
			default:      mapped  = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
			avs_response <= 2'b00;
		end else begin
			avs_readdata <= avs_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			avs_response <= ((avs_read || avs_write) && !mapped) ? 2'b10 : 2'b00;
		end
	end

	// Read waits one cycle so data comes from flops
	logic rd_pend;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rd_pend <= 1'b0;
		else
			rd_pend <= avs_read && !rd_pend;
	end
	assign avs_waitrequest = avs_read && !rd_pend;

endmodule

// ==== tb/tlv_irq_asserts.sv ====
/*
 Checker for tlv_irq_unit: call, gating, priority and flag relations.
 Sees only the unit's ports; bound to every instance of the unit below.
*/
module tlv_irq_asserts
	import tlv_pkg::*;
#(
	parameter bit HAS_TIMER2 = 1'b1
) (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	input wire logic        ext0_request_pin,
	input wire logic        ext1_request_pin,
	input wire tlv_hw_set_t hw_set,
	input wire tlv_core_t   core,
	input wire tlv_call_t   call,
	input wire logic [7:0]  flag_view
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] en_s;
	logic [7:0] pr_s;
	logic [1:0] busy;
	logic [3:0] ph;
	logic       req_q;
	logic       seen;

	// Shadows of enable and priority writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_s <= 8'h00;
			pr_s <= 8'h00;
		end else if (avs_write && avs_byteenable[0]) begin
			if (avs_address == OFS_ENABLE)
				en_s <= avs_writedata[7:0];
			if (avs_address == OFS_PRIORITY)
				pr_s <= avs_writedata[7:0];
		end
	end

	// Levels in progress
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			busy <= 2'b00;
		else if (call.req && core.call_done)
			busy[pr_s[call.src]] <= 1'b1;
		else if (core.return_from_handler)
			busy <= busy[1] ? {1'b0, busy[0]} : 2'b00;
	end

	// Clocks since the last call, modulo one machine cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ph <= 4'h0;
			req_q <= 1'b0;
			seen <= 1'b0;
		end else begin
			req_q <= call.req;
			if (call.req && !req_q) begin
				ph <= 4'h1;
				seen <= 1'b1;
			end else
				ph <= (ph == 4'hb) ? 4'h0 : ph + 4'h1;
		end
	end

	default clocking dcb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_done;
		call.req && core.call_done;
	endsequence

	sequence s_start;
		$rose(call.req);
	endsequence

	vec_map_a: assert property (
		call.req |-> call.vector == VECTOR_BASE + VECTOR_STEP * call.src)
		else $error("Call vector wrong for source");
	call_hold_a: assert property (
		call.req && !core.call_done |=> call.req && $stable(call.src))
		else $error("Call dropped or changed before completion");
	call_end_a: assert property (
		s_done |=> !call.req)
		else $error("Call still raised after completion");
	gate_on_a: assert property (
		s_start |-> en_s[EN_GLOBAL_BIT] && en_s[call.src])
		else $error("Call raised for a disabled source");
	no_preempt_a: assert property (
		s_start |-> !busy[1] && !(busy[0] && !pr_s[call.src]))
		else $error("Call raised over a level in progress");
	final_only_a: assert property (
		s_start |-> $past(core.final_cycle))
		else $error("Call raised outside a final cycle");
	poll_phase_a: assert property (
		s_start and seen |-> ph == 4'h0)
		else $error("Call raised off the polling phase");
	tmr_clear_a: assert property (
		s_done and call.src == 3'(SRC_TMR0) && !hw_set.tmr0_ovf |=> !flag_view[TC_TF0_BIT])
		else $error("Timer flag kept after vectoring");
	edge_clear_a: assert property (
		s_done and call.src == 3'(SRC_EXT0) && flag_view[TC_IT0_BIT] |=> !flag_view[TC_IE0_BIT])
		else $error("Edge request flag kept after vectoring");
	level_keep_a: assert property (
		s_done and call.src == 3'(SRC_EXT0) && !flag_view[TC_IT0_BIT] && !ext0_request_pin
		|=> flag_view[TC_IE0_BIT])
		else $error("Level request flag cleared by vectoring");
	tf_set_a: assert property (
		hw_set.tmr1_ovf |=> flag_view[TC_TF1_BIT])
		else $error("Timer rollover did not set its flag");
	rd_wait_a: assert property (
		avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("Read wait longer than one cycle");
endmodule

bind tlv_irq_unit tlv_irq_asserts #(.HAS_TIMER2(HAS_TIMER2)) u_chk (
	.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.avs_response(avs_response), .ext0_request_pin(ext0_request_pin),
	.ext1_request_pin(ext1_request_pin), .hw_set(hw_set), .core(core), .call(call),
	.flag_view(flag_view));

// ==== tb/tlv_core_model.sv ====
/*
 Core sequencer model: completes each call after lag+1 clocks, records the
 vector taken, and issues returns when the bench asks. One clock domain.
*/
module tlv_core_model
	import tlv_pkg::*;
(
	input wire logic       clk,
	input wire logic       resetn,
	input wire tlv_call_t  call,
	input wire logic       fin,
	input wire logic       return_from_handler_cmd,
	input wire logic [3:0] lag,
	output tlv_core_t      core,
	output logic [15:0]    last_vec
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] cnt;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 4'h0;
			core <= '0;
			last_vec <= 16'h0000;
		end else begin
			core.final_cycle <= fin;
			core.return_from_handler <= return_from_handler_cmd;
			core.ie_ip_access <= 1'b0;
			core.call_done <= 1'b0;
			if (call.req && !core.call_done) begin
				if (cnt == lag) begin
					core.call_done <= 1'b1;
					last_vec <= call.vector;
					cnt <= 4'h0;
				end else
					cnt <= cnt + 4'h1;
			end
		end
	end
endmodule

// ==== tb/tlv_irq_unit_test.sv ====
/*
 Self-checking bench for tlv_irq_unit with the core model as partner.
 Assumes a 20 MHz clock and the register map of the package.
*/
module tlv_irq_unit_test
	import tlv_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        resetn;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [1:0]  avs_response;
	logic        ext0_request_pin;
	logic        ext1_request_pin;
	tlv_hw_set_t hw_set;
	tlv_core_t   core;
	tlv_call_t   call;
	logic [7:0]  flag_view;
	logic [15:0] last_vec;
	logic        return_from_handler_cmd;
	logic [3:0]  lag;
	int          n_fail;
	int          num_checks;
	localparam logic [7:0] TV [6] = '{8'had, 8'h8d, 8'h85, 8'h05, 8'h05, 8'h05};

	tlv_irq_unit dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.ext0_request_pin(ext0_request_pin), .ext1_request_pin(ext1_request_pin),
		.hw_set(hw_set), .core(core), .call(call), .flag_view(flag_view));
	tlv_core_model partner (.clk(clk), .resetn(resetn), .call(call), .fin(1'b1),
		.return_from_handler_cmd(return_from_handler_cmd), .lag(lag), .core(core), .last_vec(last_vec));

	always #25 clk = ~clk;

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q, output logic [1:0] r);
		int i;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		@(negedge clk);
		for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i++)
			@(negedge clk);
		if (i == 20) begin
			n_fail++;
			stop_test();
		end
		// Answer taken at the edge where waitrequest is seen low
		@(posedge clk);
		q = avs_readdata[7:0];
		r = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic [1:0] r;
		bus(a, 1'b1, d, q, r);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] re);
		logic [7:0] q;
		logic [1:0] r;
		bus(a, 1'b0, 8'h00, q, r);
		chk(16'(q), 16'(e));
		chk(16'(r), 16'(re));
	endtask

	task automatic waitreq(input logic v);
		int i;
		for (i = 0; i < 400 && call.req !== v; i++)
			@(negedge clk);
		if (i == 400) begin
			n_fail++;
			stop_test();
		end
	endtask

	task automatic want(input logic [2:0] s);
		waitreq(1'b1);
		chk(16'(call.src), 16'(s));
		chk(call.vector, VECTOR_BASE + VECTOR_STEP * s);
		waitreq(1'b0);
		chk(last_vec, VECTOR_BASE + VECTOR_STEP * s);
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			@(negedge clk);
			chk(16'(call.req), 16'h0);
		end
	endtask

	task automatic ret_handler;
		@(posedge clk) return_from_handler_cmd <= 1'b1;
		@(posedge clk) return_from_handler_cmd <= 1'b0;
	endtask

	task automatic hw(input tlv_hw_set_t v);
		@(posedge clk) hw_set <= v;
		@(posedge clk) hw_set <= '0;
		@(negedge clk);
	endtask

	task automatic t_regs;
		for (int a = 0; a < 5; a++)
			rd(4'(a), 8'h00, 2'b00);
		rd(4'h5, 8'h00, 2'b10);
		wr(OFS_ENABLE, 8'hff);
		rd(OFS_ENABLE, 8'hbf, 2'b00);
		avs_byteenable <= 4'h0;
		wr(OFS_ENABLE, 8'h55);
		avs_byteenable <= 4'h1;
		rd(OFS_ENABLE, 8'hbf, 2'b00);
		wr(OFS_PRIORITY, 8'hff);
		rd(OFS_PRIORITY, 8'h3f, 2'b00);
		wr(OFS_PRIORITY, 8'h00);
	endtask

	task automatic t_order;
		wr(OFS_TIMER_CONTROL_REG, 8'haf);
		wr(OFS_FLAGS, 8'h0f);
		for (int s = 0; s < 6; s++) begin
			want(3'(s));
			chk(16'(flag_view), 16'(TV[s]));
			if (s == 4) begin
				rd(OFS_FLAGS, 8'h0f, 2'b00);
				wr(OFS_FLAGS, 8'h0c);
			end
			if (s == 5) begin
				rd(OFS_FLAGS, 8'h0c, 2'b00);
				wr(OFS_FLAGS, 8'h00);
			end
			ret_handler();
		end
		quiet(36);
	endtask

	task automatic t_prio;
		wr(OFS_ENABLE, 8'h3f);
		wr(OFS_PRIORITY, 8'h10);
		hw(tlv_hw_set_t'(6'h08)); // Receive done
		wr(OFS_TIMER_CONTROL_REG, 8'h07);
		wr(OFS_ENABLE, 8'hbf);
		want(3'd4);
		quiet(36);
		wr(OFS_FLAGS, 8'h00);
		ret_handler();
		want(3'd0);
		ret_handler();
		wr(OFS_PRIORITY, 8'h00);
	endtask

	task automatic t_gate;
		wr(OFS_ENABLE, 8'h08);
		hw(tlv_hw_set_t'(6'h02)); // Timer-1 rollover
		chk(16'(flag_view[TC_TF1_BIT]), 16'h1);
		quiet(36);
		wr(OFS_ENABLE, 8'hb7);
		quiet(36);
		wr(OFS_ENABLE, 8'hbf);
		want(3'd3);
		chk(16'(flag_view[TC_TF1_BIT]), 16'h0);
		ret_handler();
	endtask

	task automatic t_level;
		wr(OFS_TIMER_CONTROL_REG, 8'h04);
		@(posedge clk) ext0_request_pin <= 1'b0;
		want(3'd0);
		chk(16'(flag_view[TC_IE0_BIT]), 16'h1);
		@(posedge clk) ext0_request_pin <= 1'b1;
		repeat (30) @(negedge clk);
		chk(16'(flag_view[TC_IE0_BIT]), 16'h0);
		ret_handler();
		quiet(36);
		@(posedge clk) ext1_request_pin <= 1'b0;
		want(3'd2);
		chk(16'(flag_view[TC_IE1_BIT]), 16'h0);
		ret_handler();
		quiet(36);
	endtask

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h1;
		ext0_request_pin = 1'b1;
		ext1_request_pin = 1'b1;
		hw_set = '0;
		return_from_handler_cmd = 1'b0;
		lag = 4'h0;
		n_fail = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_regs();
		lag <= 4'h6;
		t_order();
		lag <= 4'h0;
		t_prio();
		t_gate();
		t_level();
		stop_test();
	end
endmodule
